/* File: design/psa_pkg.sv */
// protection settings alarm block: shared constants and types
// Notes on behaviour
// - write-settings command word 0x63657373, request frame is exactly 28 bytes
// - accepted write request answered by a frame holding only the echoed word
// - read command 0x63657367, 4-byte request, 28-byte answer shaped like write; its top byte is compared as left by the previous frame
// - payload: seven 16-bit limits, flag byte, 7 reserved bytes, 16-bit checksum
// - undervoltage flag set: motor off while supply below lower limit
// - alarm when motor current exceeds its limit
// - alarm when motor supply voltage exceeds its limit
// - alarm when temperature exceeds its limit in tenths of a degree
// - alarm when host supply current exceeds its limit
// - alarm when host supply voltage exceeds its maximum
// - alarm when host supply voltage falls below its minimum
// - overheat flag set: driver overheat signal raises alarm
// - bridge flag set: power stage off on any bridge fault
// - border flag set: misconfigured borders raise alarm
// - sticky flag set: alarms latch, only stop clears them
// - reconnect flag set: connection recovery module enabled
// - border misconfiguration detection makes motor stop at both borders
package psa_pkg;
	localparam logic [31:0] CMD_WRITE = 32'h63657373;
	localparam logic [31:0] CMD_READ = 32'h63657367;
	localparam logic [5:0] LEN_SETTINGS = 6'h1C;
	localparam logic [5:0] LEN_CMD = 6'h04;
	localparam logic [5:0] LEN_MAX = 6'h3F;
	localparam logic [5:0] POS_LIMITS = 6'h04;
	localparam logic [5:0] POS_FLAGS = 6'h12;
	localparam int N_LIMITS = 7;
	// limit indices in frame order
	localparam int LIM_UV = 0;
	localparam int LIM_MOTOR_MA = 1;
	localparam int LIM_MOTOR_MV = 2;
	localparam int LIM_TEMP = 3;
	localparam int LIM_HOST_MA = 4;
	localparam int LIM_HOST_MAX = 5;
	localparam int LIM_HOST_MIN = 6;
	// flag bit positions
	localparam int FL_OVERHEAT = 0;
	localparam int FL_UNDERVOLT = 1;
	localparam int FL_BRIDGE = 2;
	localparam int FL_BORDER = 3;
	localparam int FL_STICKY = 4;
	localparam int FL_RECONNECT = 5;
	localparam logic [7:0] FLAGS_DEFINED = 8'h3F;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] LIMIT_MAX_RESET = 16'hFFFF;
	localparam logic [15:0] LIMIT_MIN_RESET = 16'h0000;
	// alarm cause bits
	localparam int AL_MOTOR_MA = 0;
	localparam int AL_MOTOR_MV = 1;
	localparam int AL_TEMP = 2;
	localparam int AL_HOST_MA = 3;
	localparam int AL_HOST_HIGH = 4;
	localparam int AL_HOST_LOW = 5;
	localparam int AL_OVERHEAT = 6;
	localparam int AL_BORDER = 7;
	// event bits of status and mask
	localparam int EV_ALARM = 0;
	localparam int EV_UNDERVOLT = 1;
	localparam int EV_BRIDGE = 2;
	localparam int EV_WRITTEN = 3;
	localparam int EV_BAD_FRAME = 4;
	localparam int N_EVENTS = 5;
	// register byte addresses
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_MASK = 4'h4;
	localparam logic [3:0] REG_ALARM = 4'h8;
	localparam logic [3:0] REG_CTRL = 4'hC;
	localparam int CTRL_STOP = 0;
	localparam logic [31:0] BUS_UNMAPPED = 32'h00000000;

	typedef struct packed {
		logic [15:0] motor_mv;
		logic [15:0] motor_ma;
		logic [15:0] temp;
		logic [15:0] host_ma;
		logic [15:0] host_mv;
	} psa_meas_s;

	typedef struct packed {
		logic [N_LIMITS-1:0][15:0] limit;
		logic [7:0] flags;
	} psa_settings_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEND = 3'b010,
		ST_HOLD = 3'b100
	} psa_state_e;
endpackage : psa_pkg

/* File: design/psa_top.sv */
// protection settings alarm block: command interpreter, limits, alarms, bus
`timescale 1ns/10ps
module psa_top
	import psa_pkg::*;
(
	input wire logic clk_in, // 25 MHz clock
	input wire logic rst_b_in, // async reset, active low
	// command link, frames already delimited by the framing layer
	input wire logic rx_valid_in, // received byte strobe
	input wire logic [7:0] rx_byte_in, // received byte
	input wire logic rx_last_in, // byte ends the frame
	output logic tx_valid_out, // answer byte valid
	output logic [7:0] tx_byte_out, // answer byte
	output logic tx_last_out, // last byte of answer
	input wire logic tx_ready_in, // framing layer takes byte
	// measurements from converter logic on this clock
	input wire psa_meas_s meas_in, // measured values
	input wire logic overheat_in, // driver overheat pin
	input wire logic bridge_fault_in, // any bridge fault pin
	input wire logic border_misset_in, // borders swapped or misset
	input wire logic border_detect_en_in, // border setting selects detection
	input wire logic stop_cmd_in, // stop command pulse
	// protection outputs
	output logic alarm_out, // alarm state
	output logic [7:0] alarm_cause_out, // alarm causes
	output logic motor_off_out, // motor switched off
	output logic power_stage_off_out, // power stage switched off
	output logic border_stop_out, // stop at both borders
	output logic reconnect_en_out, // connection recovery enabled
	// avalon-mm slave
	input wire logic [3:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	output logic irq_out // level interrupt
);

	psa_state_e state;
	psa_settings_s settings;
	psa_settings_s shadow;
	logic [31:0] cmd_word;
	logic [5:0] rx_count;
	logic [5:0] tx_index;
	logic [5:0] tx_len;
	logic [31:0] tx_cmd;
	logic [1:0] overheat_sync;
	logic [1:0] bridge_sync;
	logic [7:0] live_cause;
	logic [7:0] cause;
	logic undervolt;
	logic alarm_prev;
	logic [N_EVENTS-1:0] status;
	logic [N_EVENTS-1:0] mask;
	logic [N_EVENTS-1:0] event_set;
	logic sw_stop;
	logic stop_any;
	logic bus_ack;
	logic bus_wr_take;
	logic frame_end;
	logic write_ok;
	logic read_ok;
	logic bad_frame;
	logic [7:0] next_tx_byte;

	// byte of the answer frame at a position, little endian fields
	function automatic logic [7:0] answer_byte(
		input psa_settings_s s,
		input logic [31:0] cmd,
		input logic [5:0] idx
	);
		logic [5:0] off;
		logic [7:0] b;
		b = 8'h00;
		off = 6'h00;
		if (idx < POS_LIMITS) begin
			b = cmd[8*idx[1:0] +: 8];
		end else if (idx < POS_FLAGS) begin
			off = idx - POS_LIMITS;
			b = s.limit[off[5:1]][8*off[0] +: 8];
		end else if (idx == POS_FLAGS) begin
			b = s.flags & FLAGS_DEFINED;
		end
		// reserved bytes and checksum slot read zero; framer fills crc
		return b;
	endfunction : answer_byte

	// compare helper used for every upper limit
	function automatic logic above(
		input logic [15:0] value,
		input logic [15:0] limit
	);
		return value > limit;
	endfunction : above

	// register select for a write taken on the edge that ends the wait
	function automatic logic reg_hit(
		input logic take,
		input logic [3:0] addr,
		input logic [3:0] want
	);
		return take && addr == want;
	endfunction : reg_hit

	// pin inputs cross into the clock domain
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			overheat_sync <= 2'h0;
			bridge_sync <= 2'h0;
		end else begin
			overheat_sync <= {overheat_sync[0], overheat_in};
			bridge_sync <= {bridge_sync[0], bridge_fault_in};
		end
	end

	assign frame_end = rx_valid_in & rx_last_in;
	// count excludes the byte that ends the frame
	assign write_ok = frame_end && cmd_word == CMD_WRITE
		&& rx_count == LEN_SETTINGS - 6'h01;
	assign read_ok = frame_end && cmd_word == CMD_READ
		&& rx_count == LEN_CMD - 6'h01;
	// frames ending while an answer is pending are dropped
	assign bad_frame = frame_end
		&& (!(write_ok || read_ok) || state != ST_IDLE);

	// receive: gather command word and payload into the shadow copy
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rx_count <= 6'h00;
			cmd_word <= 32'h00000000;
		end else if (rx_valid_in) begin
			if (rx_last_in) begin
				rx_count <= 6'h00;
			end else if (rx_count != LEN_MAX) begin
				rx_count <= rx_count + 6'h01;
			end
			if (rx_count < LEN_CMD) begin
				cmd_word[8*rx_count[1:0] +: 8] <= rx_byte_in;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			shadow <= '0;
		end else if (rx_valid_in && rx_count >= POS_LIMITS) begin
			if (rx_count < POS_FLAGS) begin
				shadow.limit[6'(rx_count - POS_LIMITS) >> 1]
					[8*(rx_count[0]) +: 8] <= rx_byte_in;
			end else if (rx_count == POS_FLAGS) begin
				shadow.flags <= rx_byte_in & FLAGS_DEFINED;
			end
			// reserved and checksum bytes are not kept
		end
	end

	// commit only a whole, well-formed write frame
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < N_LIMITS; i++) begin
				settings.limit[i] <= LIMIT_MAX_RESET;
			end
			settings.limit[LIM_UV] <= LIMIT_MIN_RESET;
			settings.limit[LIM_HOST_MIN] <= LIMIT_MIN_RESET;
			settings.flags <= FLAGS_RESET;
		end else if (write_ok && state == ST_IDLE) begin
			settings <= shadow;
			// last byte of a 28-byte frame is checksum, shadow is complete
		end
	end

	// answer sequencer
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= ST_IDLE;
			tx_index <= 6'h00;
			tx_len <= 6'h00;
			tx_cmd <= 32'h00000000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (write_ok) begin
						tx_cmd <= CMD_WRITE;
						tx_len <= LEN_CMD;
						tx_index <= 6'h00;
						state <= ST_HOLD;
					end else if (read_ok) begin
						tx_cmd <= CMD_READ;
						tx_len <= LEN_SETTINGS;
						tx_index <= 6'h00;
						state <= ST_HOLD;
					end
				end
				// one cycle for the committed settings to settle
				ST_HOLD: begin
					state <= ST_SEND;
				end
				ST_SEND: begin
					if (tx_ready_in) begin
						if (tx_index == tx_len - 6'h01) begin
							state <= ST_IDLE;
						end else begin
							tx_index <= tx_index + 6'h01;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	assign next_tx_byte = answer_byte(settings, tx_cmd, tx_index);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tx_byte_out <= 8'h00;
			tx_last_out <= 1'b0;
		end else begin
			tx_byte_out <= next_tx_byte;
			tx_last_out <= 1'b0;
			if (state == ST_HOLD) begin
				tx_byte_out <= answer_byte(settings, tx_cmd, 6'h00);
				tx_last_out <= (tx_len == 6'h01);
			end else if (state == ST_SEND && tx_ready_in) begin
				tx_byte_out <= answer_byte(settings, tx_cmd,
					tx_index + 6'h01);
				tx_last_out <= (tx_index + 6'h02 == tx_len);
			end else if (state == ST_SEND) begin
				tx_byte_out <= tx_byte_out;
				tx_last_out <= tx_last_out;
			end
		end
	end

	assign tx_valid_out = (state == ST_SEND);

	// live limit checks
	always_comb begin
		live_cause = 8'h00;
		live_cause[AL_MOTOR_MA] = above(meas_in.motor_ma,
			settings.limit[LIM_MOTOR_MA]);
		live_cause[AL_MOTOR_MV] = above(meas_in.motor_mv,
			settings.limit[LIM_MOTOR_MV]);
		live_cause[AL_TEMP] = above(meas_in.temp,
			settings.limit[LIM_TEMP]);
		live_cause[AL_HOST_MA] = above(meas_in.host_ma,
			settings.limit[LIM_HOST_MA]);
		live_cause[AL_HOST_HIGH] = above(meas_in.host_mv,
			settings.limit[LIM_HOST_MAX]);
		live_cause[AL_HOST_LOW] = above(settings.limit[LIM_HOST_MIN],
			meas_in.host_mv);
		live_cause[AL_OVERHEAT] = overheat_sync[1]
			& settings.flags[FL_OVERHEAT];
		live_cause[AL_BORDER] = border_misset_in
			& settings.flags[FL_BORDER];
	end

	assign undervolt = settings.flags[FL_UNDERVOLT]
		&& above(settings.limit[LIM_UV], meas_in.motor_mv);
	assign stop_any = stop_cmd_in | sw_stop;

	// alarm causes: latched when sticky, new causes win over stop
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cause <= 8'h00;
		end else if (settings.flags[FL_STICKY]) begin
			cause <= live_cause | (stop_any ? 8'h00 : cause);
		end else begin
			cause <= live_cause;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			motor_off_out <= 1'b0;
			power_stage_off_out <= 1'b0;
			border_stop_out <= 1'b0;
			reconnect_en_out <= 1'b0;
			alarm_prev <= 1'b0;
		end else begin
			motor_off_out <= undervolt;
			power_stage_off_out <= settings.flags[FL_BRIDGE]
				& bridge_sync[1];
			border_stop_out <= border_detect_en_in
				& border_misset_in;
			reconnect_en_out <= settings.flags[FL_RECONNECT];
			alarm_prev <= |cause;
		end
	end

	assign alarm_out = |cause;
	assign alarm_cause_out = cause;

	// event sources for the interrupt status
	always_comb begin
		event_set = '0;
		event_set[EV_ALARM] = (|cause) & ~alarm_prev;
		event_set[EV_UNDERVOLT] = undervolt & ~motor_off_out;
		event_set[EV_BRIDGE] = settings.flags[FL_BRIDGE]
			& bridge_sync[1] & ~power_stage_off_out;
		event_set[EV_WRITTEN] = write_ok & (state == ST_IDLE);
		event_set[EV_BAD_FRAME] = bad_frame;
	end

	// bus: one wait state, answer on the second edge of a request
	assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
	// all writable fields sit in byte lane 0, other lanes are ignored
	assign bus_wr_take = avs_write & bus_ack & avs_byteenable[0];

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= (avs_read | avs_write) & ~bus_ack;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read && !bus_ack) begin
			case (avs_address)
				REG_STATUS: avs_readdata <= 32'(status);
				REG_MASK: avs_readdata <= 32'(mask);
				REG_ALARM: avs_readdata <= 32'(cause);
				REG_CTRL: avs_readdata <= 32'(settings.flags);
				default: avs_readdata <= BUS_UNMAPPED;
			endcase
		end
	end

	// status: write one to clear, a new event in the same cycle wins
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			status <= '0;
		end else if (reg_hit(bus_wr_take, avs_address, REG_STATUS)) begin
			status <= (status & ~avs_writedata[N_EVENTS-1:0]) | event_set;
		end else begin
			status <= status | event_set;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mask <= '0;
		end else if (reg_hit(bus_wr_take, avs_address, REG_MASK)) begin
			mask <= avs_writedata[N_EVENTS-1:0];
		end
	end

	// software stop is a one-cycle pulse from a write of the stop bit
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sw_stop <= 1'b0;
		end else begin
			sw_stop <= reg_hit(bus_wr_take, avs_address, REG_CTRL)
				&& avs_writedata[CTRL_STOP];
		end
	end

	assign irq_out = |(status & mask);

endmodule : psa_top

/* File: tb/psa_host_model.sv */
// host model: sends command frames and takes answers with stalls
`timescale 1ns/10ps
module psa_host_model (
	input wire logic clk_in, // clock
	output logic rx_valid_out, // byte strobe
	output logic [7:0] rx_byte_out, // byte
	output logic rx_last_out, // frame end
	input wire logic tx_valid_in, // answer valid
	input wire logic [7:0] tx_byte_in, // answer byte
	input wire logic tx_last_in, // answer end
	output logic tx_ready_out // answer taken
);
	logic [7:0] q[$];
	initial begin
		rx_valid_out = 1'b0;
		rx_byte_out = 8'h00;
		rx_last_out = 1'b0;
		tx_ready_out = 1'b0;
	end
	// one frame at a time, whole, no gaps
	task send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			rx_valid_out <= 1'b1;
			rx_byte_out <= b[i];
			rx_last_out <= (i == b.size() - 1);
			@(posedge clk_in);
		end
		rx_valid_out <= 1'b0;
		rx_last_out <= 1'b0;
		rx_byte_out <= ~b[b.size() - 1]; // idle line shows no stale byte
	endtask : send
	task take(input int lim);
		int k;
		logic done;
		q = {};
		done = 1'b0;
		for (k = 0; k < lim && !done; k++) begin
			tx_ready_out <= 1'($urandom_range(1));
			// byte is taken at the very edge on which the design advances
			@(posedge clk_in);
			if (tx_valid_in && tx_ready_out) begin
				q.push_back(tx_byte_in);
				done = tx_last_in;
			end
		end
		tx_ready_out <= 1'b0;
	endtask : take
endmodule : psa_host_model

/* File: tb/psa_properties.sv */
// port-level assertions and covers for the protection settings block
`timescale 1ns/10ps
module psa_properties
	import psa_pkg::*;
(
	input wire logic clk_in, // clock
	input wire logic rst_b_in, // reset, active low
	input wire logic rx_valid_in, // byte strobe
	input wire logic rx_last_in, // frame end
	input wire logic tx_valid_out, // answer valid
	input wire logic [7:0] tx_byte_out, // answer byte
	input wire logic tx_last_out, // answer end
	input wire logic tx_ready_in, // answer taken
	input wire logic border_misset_in, // borders misset
	input wire logic border_detect_en_in, // detection selected
	input wire logic alarm_out, // alarm level
	input wire logic [7:0] alarm_cause_out, // causes
	input wire logic border_stop_out, // border stop
	input wire logic avs_read, // bus read
	input wire logic avs_write, // bus write
	input wire logic [31:0] avs_readdata, // bus data
	input wire logic avs_waitrequest, // bus stall
	input wire logic irq_out // interrupt
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	AST_ALARM_OR: assert property (alarm_out == |alarm_cause_out)
		else $error("alarm level differs from causes");
	AST_BORDER_STOP: assert property ($past(rst_b_in) |->
		border_stop_out == $past(border_detect_en_in && border_misset_in))
		else $error("border stop not from detection");
	AST_WAIT_FIRST: assert property ($rose(avs_read || avs_write) |->
		avs_waitrequest) else $error("no wait state on new request");
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("wait state too long");
	AST_RDATA_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without read");
	AST_TX_HOLD: assert property (tx_valid_out && !tx_ready_in |=>
		tx_valid_out && $stable(tx_byte_out) && $stable(tx_last_out))
		else $error("answer byte dropped before taken");
	AST_TX_DELAY: assert property ($rose(tx_valid_out) |->
		$past(rx_valid_in && rx_last_in, 2)) else $error("answer mistimed");
	AST_TX_FIRST: assert property ($rose(tx_valid_out) |->
		tx_byte_out inside {8'h73, 8'h67}) else $error("bad echo byte");
	cover property ($rose(alarm_out));
	cover property ($rose(irq_out));
	cover property (tx_valid_out && tx_ready_in && tx_last_out);
endmodule : psa_properties
bind psa_top psa_properties u_psa_properties (.clk_in(clk_in),
	.rst_b_in(rst_b_in), .rx_valid_in(rx_valid_in), .rx_last_in(rx_last_in),
	.tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out),
	.tx_last_out(tx_last_out), .tx_ready_in(tx_ready_in),
	.border_misset_in(border_misset_in),
	.border_detect_en_in(border_detect_en_in), .alarm_out(alarm_out),
	.alarm_cause_out(alarm_cause_out), .border_stop_out(border_stop_out),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq_out(irq_out));

/* File: tb/tb_top.sv */
// self-checking bench for the protection settings block
`timescale 1ns/10ps
module tb_top;
	import psa_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic rx_valid, rx_last, tx_valid, tx_last, tx_ready, wt, alarm;
	logic [7:0] rx_byte, tx_byte, cause, fl;
	logic ovh = 1'b0, brf = 1'b0, bmis = 1'b0, bden = 1'b0, stp = 1'b0;
	logic moff, psoff, bstop, recon, irq, rd = 1'b0, wr = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = '0, rdata, d;
	logic [15:0] lim[7];
	logic [7:0] f[$];
	psa_meas_s meas = '0, m;
	psa_meas_s base = '{16'h05DC, 16'h0064, 16'h00C8, 16'h0064, 16'h1388};
	int err_total = 0, num_checks = 0;
	always #20 clk_in = ~clk_in;
	psa_host_model u_psa_host_model (.clk_in(clk_in), .rx_valid_out(rx_valid),
		.rx_byte_out(rx_byte), .rx_last_out(rx_last), .tx_valid_in(tx_valid),
		.tx_byte_in(tx_byte), .tx_last_in(tx_last), .tx_ready_out(tx_ready));
	psa_top u_psa_top (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .rx_last_in(rx_last),
		.tx_valid_out(tx_valid), .tx_byte_out(tx_byte), .tx_last_out(tx_last),
		.tx_ready_in(tx_ready), .meas_in(meas), .overheat_in(ovh),
		.bridge_fault_in(brf), .border_misset_in(bmis),
		.border_detect_en_in(bden), .stop_cmd_in(stp), .alarm_out(alarm),
		.alarm_cause_out(cause), .motor_off_out(moff),
		.power_stage_off_out(psoff), .border_stop_out(bstop),
		.reconnect_en_out(recon), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
		.avs_readdata(rdata), .avs_waitrequest(wt), .irq_out(irq));
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		int k;
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= v;
		// waitrequest and data are read at the edge, before it updates them
		for (k = 0; k < 20; k++) begin
			@(posedge clk_in);
			if (wt === 1'b0)
				break;
		end
		if (k == 20) begin
			chk(1'b1, 1'b0);
			tally_and_finish();
		end
		d = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk_in);
	endtask : bus
	// poll on the falling edge so a register update never races the read
	task waitc(input logic [7:0] e);
		for (int k = 0; k < 8 && cause !== e; k++)
			@(negedge clk_in);
		chk(cause, e);
		@(posedge clk_in);
	endtask : waitc
	task setm(input int i, input logic [15:0] v);
		m = base;
		case (i)
			0: m.motor_ma = v;
			1: m.motor_mv = v;
			2: m.temp = v;
			3: m.host_ma = v;
			default: m.host_mv = v;
		endcase
		meas <= m;
	endtask : setm
	function automatic void put16(input logic [15:0] v);
		f.push_back(v[7:0]);
		f.push_back(v[15:8]);
	endfunction : put16
	task wr_set(input logic [7:0] fv);
		f = {8'h73, 8'h73, 8'h65, 8'h63};
		for (int i = 0; i < 7; i++)
			put16(lim[i]);
		f.push_back(fv);
		repeat (7) f.push_back(8'($urandom)); // reserved, random on purpose
		put16(16'($urandom));
		u_psa_host_model.send(f);
		u_psa_host_model.take(100);
		chk(u_psa_host_model.q.size(), 4);
		foreach (u_psa_host_model.q[i])
			chk(u_psa_host_model.q[i], f[i]);
	endtask : wr_set
	task rd_set(input logic [7:0] fv);
		f = {8'h67, 8'h73, 8'h65, 8'h63};
		u_psa_host_model.send(f);
		u_psa_host_model.take(200);
		for (int i = 0; i < 7; i++)
			put16(lim[i]);
		f.push_back(fv & FLAGS_DEFINED);
		repeat (9) f.push_back(8'h00);
		chk(u_psa_host_model.q.size(), 28);
		foreach (f[i])
			chk(u_psa_host_model.q[i], f[i]);
	endtask : rd_set
	initial begin
		repeat (50000) @(posedge clk_in);
		chk(1'b0, 1'b1);
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h71F0E374));
		repeat (12) @(posedge clk_in);
		rst_b_in <= 1'b1;
		@(posedge clk_in);
		bus(1'b0, REG_CTRL, '0);
		chk(d, '0);
		bus(1'b0, 4'h2, '0);
		chk(d, BUS_UNMAPPED);
		foreach (lim[i])
			lim[i] = 16'($urandom);
		fl = 8'($urandom) | 8'h20;
		wr_set(fl);
		chk(recon, 1'b1);
		bus(1'b0, REG_CTRL, '0);
		chk(d, {24'h000000, fl & FLAGS_DEFINED});
		rd_set(fl);
		$display("test settings frames done");
		lim = '{16'h03E8, 16'h01F4, 16'h07D0, 16'h012C, 16'h0190, 16'h1450,
			16'h12C0};
		meas <= base;
		wr_set(8'h0F);
		waitc(8'h00);
		bus(1'b1, REG_STATUS, 32'h0000001F);
		bus(1'b1, REG_MASK, '0);
		for (int i = 0; i < 6; i++) begin
			setm(i, lim[i + 1]);
			waitc(8'h00);
			setm(i, (i == 5) ? lim[i + 1] - 16'h0001 : lim[i + 1] + 16'h0001);
			waitc(8'h01 << i);
			meas <= base;
			waitc(8'h00);
		end
		chk(irq, 1'b0);
		bus(1'b1, REG_MASK, 32'h00000001);
		chk(irq, 1'b1);
		bus(1'b1, REG_STATUS, 32'h00000001);
		chk(irq, 1'b0);
		ovh <= 1'b1;
		waitc(8'h40);
		ovh <= 1'b0;
		bmis <= 1'b1;
		bden <= 1'b1;
		waitc(8'hC0);
		chk(bstop, 1'b1);
		bmis <= 1'b0;
		waitc(8'h00);
		setm(1, 16'h03E7);
		brf <= 1'b1;
		repeat (5) @(posedge clk_in);
		chk(moff, 1'b1);
		chk(psoff, 1'b1);
		bus(1'b0, REG_STATUS, '0);
		chk(d[2:1], 2'b11);
		brf <= 1'b0;
		meas <= base;
		$display("test limits and events done");
		wr_set(8'h10);
		bus(1'b0, REG_STATUS, '0);
		chk(d[EV_WRITTEN], 1'b1);
		setm(0, 16'h01F5);
		waitc(8'h01);
		chk(alarm, 1'b1);
		meas <= base;
		ovh <= 1'b1;
		repeat (5) @(posedge clk_in);
		chk(cause, 8'h01);
		ovh <= 1'b0;
		bus(1'b1, REG_CTRL, 32'h00000001);
		waitc(8'h00);
		setm(3, 16'h0191);
		waitc(8'h08);
		meas <= base;
		stp <= 1'b1;
		@(posedge clk_in);
		stp <= 1'b0;
		waitc(8'h00);
		f = {8'h73, 8'h73, 8'h65, 8'h63, 8'h00};
		u_psa_host_model.send(f);
		u_psa_host_model.take(20);
		chk(u_psa_host_model.q.size(), 0);
		bus(1'b0, REG_STATUS, '0);
		chk(d[EV_BAD_FRAME], 1'b1);
		$display("test sticky and refusal done");
		tally_and_finish();
	end
endmodule : tb_top
